/* File: icr_cfg.svh */
// Constants for the input conditioning and run/stop block
`ifndef ICR_CFG_SVH
`define ICR_CFG_SVH

`define ICR_NUM_IN        14
`define ICR_NUM_FAST      8
`define ICR_NUM_TASK      4
`define ICR_CLK_HZ        100000000
`define ICR_TICK_MS       1
`define ICR_TICK_CYC      ((`ICR_CLK_HZ / 1000) * `ICR_TICK_MS)
`define ICR_FILT_W        8
`define ICR_FILT_RST      8'h00
`define ICR_BOUNCE_W      16
`define ICR_BOUNCE_RST    16'h0000

// Register byte offsets
`define ICR_OFF_STATE     6'h00
`define ICR_OFF_RUNCFG    6'h04
`define ICR_OFF_RUNCMD    6'h08
`define ICR_OFF_IRQ_STAT  6'h0C
`define ICR_OFF_IRQ_MASK  6'h10
`define ICR_OFF_SCAN      6'h14
`define ICR_OFF_LATCHED   6'h18
`define ICR_OFF_ROLE_BASE 6'h20
`define ICR_OFF_FILT      6'h24
`define ICR_OFF_CHSEL     6'h28

// Status bit positions and status width
`define ICR_IRQ_EVT0      0
`define ICR_IRQ_LATCH     4
`define ICR_IRQ_RUN       5
`define ICR_IRQ_STOP      6
`define ICR_IRQ_W         7

`endif

/* File: icr_pkg.sv */
// Types for the input conditioning and run/stop block
package icr_pkg;

  typedef enum logic [2:0] {
    ICR_ROLE_NONE,
    ICR_ROLE_RUNSTOP,
    ICR_ROLE_LATCH,
    ICR_ROLE_EVENT,
    ICR_ROLE_COUNTER,
    ICR_ROLE_PULSE
  } icr_role_e;

  typedef enum logic [1:0] {
    ICR_EDGE_RISE,
    ICR_EDGE_FALL,
    ICR_EDGE_BOTH
  } icr_edge_e;

  typedef struct packed {
    icr_role_e  role;
    icr_edge_e  edge_sel;
    logic [1:0] task_sel;
    logic       bounce_en;
    logic [7:0] filt_ms;
  } icr_chcfg_s;

  typedef struct packed {
    logic [5:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } icr_avreq_s;

endpackage

/* File: icr_tick.sv */
// Millisecond tick divider
`timescale 1ns/1ns
`include "icr_cfg.svh"

module icr_tick #(
  parameter int CYCLES = `ICR_TICK_CYC
) (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic reset_i,
  // Tick
  output logic      tick_o
);

  initial begin
    if (CYCLES < 2) begin
      $error("icr_tick: CYCLES too small");
    end
  end

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } icr_tick_s;

  icr_tick_s st_reg;
  icr_tick_s st_next;

  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (st_reg.cnt == 32'(CYCLES - 1)) begin
      st_next.cnt = 32'h0;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 32'h1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick_o = st_reg.tick;

endmodule

/* File: icr_filter.sv */
// Integrator and bounce filter for one input
`timescale 1ns/1ns
`include "icr_cfg.svh"

module icr_filter #(
  parameter int W  = `ICR_FILT_W,
  parameter int BW = `ICR_BOUNCE_W
) (
  // Clock and reset
  input  wire logic         clock_i,
  input  wire logic         reset_i,
  // Control
  input  wire logic         tick_i,
  input  wire logic         bounce_i,
  input  wire logic [W-1:0] limit_i,
  input  wire logic         raw_i,
  // Result
  output logic              level_o
);

  initial begin
    if (W < 1 || BW < W) begin
      $error("icr_filter: bad widths");
    end
  end

  typedef struct packed {
    logic [W-1:0]  integ;
    logic [BW-1:0] stable;
    logic          last;
    logic          level;
  } icr_filt_s;

  icr_filt_s st_reg;
  icr_filt_s st_next;

  always_comb begin
    st_next = st_reg;
    st_next.last = raw_i;
    if (bounce_i) begin
      // Level taken after raw holds still for limit ticks
      if (raw_i != st_reg.last) begin
        st_next.stable = '0;
      end else if (tick_i && st_reg.stable < BW'(limit_i)) begin
        st_next.stable = st_reg.stable + BW'(1);
      end
      if (raw_i == st_reg.last && st_reg.stable >= BW'(limit_i)) begin
        st_next.level = raw_i;
      end
    end else begin
      if (tick_i) begin
        if (raw_i && st_reg.integ < limit_i) begin
          st_next.integ = st_reg.integ + W'(1);
        end else if (!raw_i && st_reg.integ != '0) begin
          st_next.integ = st_reg.integ - W'(1);
        end
      end
      if (st_next.integ >= limit_i && raw_i) begin
        st_next.level = 1'b1;
      end else if (st_next.integ == '0 && !raw_i) begin
        st_next.level = 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level_o = st_reg.level;

endmodule

/* File: icr_top.sv */
// Input conditioning with latch, events and run/stop control
`timescale 1ns/1ns
`include "icr_cfg.svh"

module icr_top #(
  parameter int NUM_IN    = `ICR_NUM_IN,
  parameter int NUM_FAST  = `ICR_NUM_FAST,
  parameter int NUM_TASK  = `ICR_NUM_TASK,
  parameter int TICK_CYC  = `ICR_TICK_CYC,
  parameter logic [13:0] COUNTER_OK = 14'h00FF,
  parameter logic [13:0] PULSE_OK   = 14'h1B00
) (
  // Clock and reset
  input  wire logic                clock_i,
  input  wire logic                reset_i,
  // Avalon-MM slave
  input  wire logic [5:0]          avs_address_i,
  input  wire logic                avs_read_i,
  input  wire logic                avs_write_i,
  input  wire logic [31:0]         avs_writedata_i,
  output logic      [31:0]         avs_readdata_o,
  output logic                     avs_waitrequest_o,
  // Field inputs and scan
  input  wire logic [NUM_IN-1:0]   raw_i,
  input  wire logic                scan_start_i,
  // Conditioned results
  output logic      [NUM_IN-1:0]   state_o,
  output logic      [NUM_IN-1:0]   lamp_o,
  output logic      [NUM_TASK-1:0] task_evt_o,
  output logic      [NUM_IN-1:0]   counter_feed_o,
  output logic      [NUM_IN-1:0]   pulse_feed_o,
  output logic                     run_o,
  output logic                     irq_o
);

  initial begin
    if (NUM_IN != `ICR_NUM_IN || NUM_FAST != `ICR_NUM_FAST ||
        NUM_TASK != `ICR_NUM_TASK) begin
      $error("icr_top: channel counts fixed by register layout");
    end
  end

  localparam int RSW = $clog2(NUM_IN);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    icr_pkg::icr_chcfg_s [NUM_IN-1:0] cfg;
    logic [NUM_IN-1:0]   last;
    logic [NUM_IN-1:0]   latch;
    logic [NUM_IN-1:0]   state;
    logic [NUM_TASK-1:0] evt;
    logic [NUM_IN-1:0]   cfeed;
    logic [NUM_IN-1:0]   pfeed;
    logic                rs_en;
    logic [RSW-1:0]      rs_sel;
    logic                rs_last;
    logic                run;
    logic [`ICR_IRQ_W-1:0] stat;
    logic [`ICR_IRQ_W-1:0] mask;
    logic [3:0]          chsel;
    logic [31:0]         rdata;
    logic                ack;
    logic                irq;
  } icr_top_s;

  icr_top_s st_reg;
  icr_top_s st_next;

  logic                tick;
  logic [NUM_IN-1:0]   filt;
  icr_pkg::icr_avreq_s req;

  assign req = '{address: avs_address_i, read: avs_read_i,
                 write: avs_write_i, writedata: avs_writedata_i};

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic is_fast(input int idx);
    return idx < NUM_FAST;
  endfunction

  // Legal role for a channel, else none
  function automatic icr_pkg::icr_role_e legal_role(
    input int                 idx,
    input icr_pkg::icr_role_e r
  );
    icr_pkg::icr_role_e res;
    res = r;
    case (r)
      icr_pkg::ICR_ROLE_LATCH,
      icr_pkg::ICR_ROLE_EVENT:
        if (!is_fast(idx)) res = icr_pkg::ICR_ROLE_NONE;
      icr_pkg::ICR_ROLE_COUNTER:
        if (!COUNTER_OK[idx]) res = icr_pkg::ICR_ROLE_NONE;
      icr_pkg::ICR_ROLE_PULSE:
        if (!PULSE_OK[idx]) res = icr_pkg::ICR_ROLE_NONE;
      icr_pkg::ICR_ROLE_NONE,
      icr_pkg::ICR_ROLE_RUNSTOP: res = r;
      default:                   res = icr_pkg::ICR_ROLE_NONE;
    endcase
    return res;
  endfunction

  function automatic logic bounce_ok(input int idx,
                                     input icr_pkg::icr_chcfg_s c);
    return c.bounce_en && is_fast(idx) &&
           (c.role == icr_pkg::ICR_ROLE_LATCH ||
            c.role == icr_pkg::ICR_ROLE_EVENT);
  endfunction

  // ************************************************************
  // Tick and filters
  // ************************************************************
  icr_tick #(
    .CYCLES (TICK_CYC)
  ) u_tick (
    .clock_i (clock_i),
    .reset_i (reset_i),
    .tick_o  (tick)
  );

  for (genvar g = 0; g < NUM_IN; g++) begin : g_filt
    icr_filter u_filter (
      .clock_i  (clock_i),
      .reset_i  (reset_i),
      .tick_i   (tick),
      .bounce_i (bounce_ok(g, st_reg.cfg[g])),
      .limit_i  (st_reg.cfg[g].filt_ms),
      .raw_i    (raw_i[g]),
      .level_o  (filt[g])
    );
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    logic [31:0] rd;
    logic        rise;
    logic        fall;
    logic        hit;
    logic        ctl;
    logic [3:0]  ch;
    icr_pkg::icr_chcfg_s nc;
    rd = 32'h0;
    rise = 1'b0;
    fall = 1'b0;
    hit = 1'b0;
    ctl = 1'b0;
    ch = st_reg.chsel;
    nc = st_reg.cfg[0];
    st_next = st_reg;
    st_next.last = filt;
    st_next.evt = '0;
    st_next.ack = 1'b0;

    // Per-channel latch, events and feeds
    for (int i = 0; i < NUM_IN; i++) begin
      rise = filt[i] && !st_reg.last[i];
      fall = !filt[i] && st_reg.last[i];
      st_next.cfeed[i] = filt[i] &&
        st_reg.cfg[i].role == icr_pkg::ICR_ROLE_COUNTER;
      st_next.pfeed[i] = filt[i] &&
        st_reg.cfg[i].role == icr_pkg::ICR_ROLE_PULSE;
      if (st_reg.cfg[i].role == icr_pkg::ICR_ROLE_LATCH) begin
        if (scan_start_i) begin
          st_next.latch[i] = 1'b0;
        end
        if (rise) begin
          st_next.latch[i] = 1'b1;
          st_next.stat[`ICR_IRQ_LATCH] = 1'b1;
        end
      end else begin
        st_next.latch[i] = 1'b0;
      end
      if (st_reg.cfg[i].role == icr_pkg::ICR_ROLE_EVENT) begin
        case (st_reg.cfg[i].edge_sel)
          icr_pkg::ICR_EDGE_RISE: hit = rise;
          icr_pkg::ICR_EDGE_FALL: hit = fall;
          icr_pkg::ICR_EDGE_BOTH: hit = rise || fall;
          default:                hit = 1'b0;
        endcase
        if (hit) begin
          st_next.evt[st_reg.cfg[i].task_sel] = 1'b1;
          st_next.stat[`ICR_IRQ_EVT0 + int'(st_reg.cfg[i].task_sel)] = 1'b1;
        end
      end
    end

    // Scan image: latched pulses shown for the scan
    if (scan_start_i) begin
      st_next.state = filt | st_reg.latch;
    end

    // Run/stop control
    ctl = filt[st_reg.rs_sel];
    st_next.rs_last = ctl;
    if (st_reg.rs_en && !ctl) begin
      st_next.run = 1'b0;
    end else if (st_reg.rs_en && ctl && !st_reg.rs_last) begin
      st_next.run = 1'b1;
    end

    // Bus access, one wait state then ack
    if ((req.read || req.write) && !st_reg.ack) begin
      st_next.ack = 1'b1;
      if (req.write) begin
        case (req.address)
          `ICR_OFF_RUNCFG: begin
            st_next.rs_en = req.writedata[0];
            st_next.rs_sel = req.writedata[RSW:1];
            for (int i = 0; i < NUM_IN; i++) begin
              if (st_reg.cfg[i].role == icr_pkg::ICR_ROLE_RUNSTOP) begin
                st_next.cfg[i].role = icr_pkg::ICR_ROLE_NONE;
              end
            end
            if (req.writedata[0] && 32'(req.writedata[RSW:1]) < NUM_IN) begin
              st_next.cfg[req.writedata[RSW:1]].role =
                icr_pkg::ICR_ROLE_RUNSTOP;
            end else begin
              st_next.rs_en = 1'b0;
            end
          end
          `ICR_OFF_RUNCMD: begin
            if (req.writedata[1]) begin
              st_next.run = 1'b0;
            end else if (req.writedata[0] && (!st_reg.rs_en || ctl)) begin
              st_next.run = 1'b1;
            end
          end
          `ICR_OFF_IRQ_STAT:
            st_next.stat = st_next.stat &
              ~(req.writedata[`ICR_IRQ_W-1:0] & ~(st_next.stat ^ st_reg.stat));
          `ICR_OFF_IRQ_MASK: st_next.mask = req.writedata[`ICR_IRQ_W-1:0];
          `ICR_OFF_CHSEL:    st_next.chsel = req.writedata[3:0];
          `ICR_OFF_ROLE_BASE: begin
            if (32'(ch) < NUM_IN) begin
              nc = st_reg.cfg[ch];
              nc.role = legal_role(int'(ch),
                icr_pkg::icr_role_e'(req.writedata[2:0]));
              if (nc.role == icr_pkg::ICR_ROLE_RUNSTOP) begin
                nc.role = st_reg.cfg[ch].role;
              end
              nc.edge_sel = icr_pkg::icr_edge_e'(req.writedata[5:4]);
              nc.task_sel = req.writedata[7:6];
              nc.bounce_en = req.writedata[8];
              if (st_reg.cfg[ch].role != icr_pkg::ICR_ROLE_RUNSTOP) begin
                st_next.cfg[ch] = nc;
              end
            end
          end
          `ICR_OFF_FILT: begin
            if (32'(ch) < NUM_IN) begin
              st_next.cfg[ch].filt_ms = req.writedata[`ICR_FILT_W-1:0];
            end
          end
          default: ;
        endcase
      end else begin
        case (req.address)
          `ICR_OFF_STATE:    rd = 32'(st_reg.state);
          `ICR_OFF_RUNCFG:   rd = 32'({st_reg.rs_sel, st_reg.rs_en});
          `ICR_OFF_RUNCMD:   rd = 32'({st_reg.rs_last, st_reg.run});
          `ICR_OFF_IRQ_STAT: rd = 32'(st_reg.stat);
          `ICR_OFF_IRQ_MASK: rd = 32'(st_reg.mask);
          `ICR_OFF_SCAN:     rd = 32'(filt);
          `ICR_OFF_LATCHED:  rd = 32'(st_reg.latch);
          `ICR_OFF_CHSEL:    rd = 32'(st_reg.chsel);
          `ICR_OFF_ROLE_BASE:
            if (32'(ch) < NUM_IN) begin
              rd = 32'({st_reg.cfg[ch].bounce_en, st_reg.cfg[ch].task_sel,
                        st_reg.cfg[ch].edge_sel, 1'b0,
                        st_reg.cfg[ch].role});
            end
          `ICR_OFF_FILT:
            if (32'(ch) < NUM_IN) begin
              rd = 32'(st_reg.cfg[ch].filt_ms);
            end
          default: rd = 32'h0;
        endcase
        st_next.rdata = rd;
      end
    end

    // Run state changes as status events
    if (st_next.run && !st_reg.run) begin
      st_next.stat[`ICR_IRQ_RUN] = 1'b1;
    end
    if (!st_next.run && st_reg.run) begin
      st_next.stat[`ICR_IRQ_STOP] = 1'b1;
    end
    st_next.irq = |(st_next.stat & st_next.mask);
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      st_reg <= '0;
      for (int i = 0; i < NUM_IN; i++) begin
        st_reg.cfg[i].filt_ms <= `ICR_FILT_RST;
      end
    end else begin
      st_reg <= st_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign avs_readdata_o    = st_reg.rdata;
  assign avs_waitrequest_o = !st_reg.ack;
  assign state_o           = st_reg.state;
  assign lamp_o            = st_reg.last;
  assign task_evt_o        = st_reg.evt;
  assign counter_feed_o    = st_reg.cfeed;
  assign pulse_feed_o      = st_reg.pfeed;
  assign run_o             = st_reg.run;
  assign irq_o             = st_reg.irq;

endmodule

/* File: icr_checker.sv */
// Port checker for the input conditioning block
`timescale 1ns/1ns

module icr_top_checker #(
  parameter int          NUM_IN     = 14,
  parameter int          NUM_FAST   = 8,
  parameter int          NUM_TASK   = 4,
  parameter logic [13:0] COUNTER_OK = 14'h00FF,
  parameter logic [13:0] PULSE_OK   = 14'h1B00
) (
  // Clock and reset
  input  wire logic                clock_i,
  input  wire logic                reset_i,
  // Register bus
  input  wire logic                avs_read_i,
  input  wire logic                avs_write_i,
  input  wire logic [31:0]         avs_readdata_o,
  input  wire logic                avs_waitrequest_o,
  // Scan and results
  input  wire logic                scan_start_i,
  input  wire logic [NUM_IN-1:0]   state_o,
  input  wire logic [NUM_IN-1:0]   lamp_o,
  input  wire logic [NUM_TASK-1:0] task_evt_o,
  input  wire logic [NUM_IN-1:0]   counter_feed_o,
  input  wire logic [NUM_IN-1:0]   pulse_feed_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  // ***************
  // Bus handshake
  // ***************
  sequence s_req;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_ack;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence

  a_ack_in_time: assert property (s_req |-> ##[1:2] s_ack)
    else $error("bus request not answered in time");
  a_ack_one_cycle: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low longer than one cycle");
  a_idle_no_ack: assert property
    (!(avs_read_i || avs_write_i) |=> avs_waitrequest_o)
    else $error("answer without request");
  a_rdata_hold: assert property (avs_waitrequest_o |-> $stable(avs_readdata_o))
    else $error("read data moved outside an answer");

  // ***************
  // Conditioned results
  // ***************
  a_evt_on_edge: assert property
    ((task_evt_o != '0) |-> !$stable(lamp_o[NUM_FAST-1:0]))
    else $error("event pulse without a fast input edge");
  a_state_at_scan: assert property (!$stable(state_o) |-> $past(scan_start_i))
    else $error("scan image moved without scan start");
  a_counter_legal: assert property ((counter_feed_o & ~COUNTER_OK) == '0)
    else $error("counter feed on a disallowed input");
  a_pulse_legal: assert property ((pulse_feed_o & ~PULSE_OK) == '0)
    else $error("pulse feed on a disallowed input");
endmodule

bind icr_top icr_top_checker #(
  .NUM_IN     (NUM_IN),
  .NUM_FAST   (NUM_FAST),
  .NUM_TASK   (NUM_TASK),
  .COUNTER_OK (COUNTER_OK),
  .PULSE_OK   (PULSE_OK)
) u_chk (
  .clock_i           (clock_i),
  .reset_i           (reset_i),
  .avs_read_i        (avs_read_i),
  .avs_write_i       (avs_write_i),
  .avs_readdata_o    (avs_readdata_o),
  .avs_waitrequest_o (avs_waitrequest_o),
  .scan_start_i      (scan_start_i),
  .state_o           (state_o),
  .lamp_o            (lamp_o),
  .task_evt_o        (task_evt_o),
  .counter_feed_o    (counter_feed_o),
  .pulse_feed_o      (pulse_feed_o)
);

/* File: icr_field.sv */
// Field sensor model driving the raw inputs
`timescale 1ns/1ns

module icr_field #(
  parameter int NUM_IN = 14
) (
  // Clock
  input  wire logic              clock_i,
  // Field lines
  output logic      [NUM_IN-1:0] raw_o
);
  initial raw_o = '0;

  // Move one line just after a clock edge
  task automatic set(input int ch, input logic v);
    @(posedge clock_i);
    raw_o[ch] <= v;
  endtask

  // Hold a line high for a number of cycles
  task automatic pulse(input int ch, input int n);
    set(ch, 1'b1);
    repeat (n) @(posedge clock_i);
    raw_o[ch] <= 1'b0;
  endtask
endmodule

/* File: testbench.sv */
// Self-checking bench for the input conditioning block
`timescale 1ns/1ns

module testbench;
  logic        clock_i;
  logic        reset_i;
  logic [5:0]  avs_address_i;
  logic        avs_read_i;
  logic        avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic [13:0] raw_i;
  logic        scan_start_i;
  logic [13:0] state_o;
  logic [13:0] lamp_o;
  logic [3:0]  task_evt_o;
  logic [13:0] counter_feed_o;
  logic [13:0] pulse_feed_o;
  logic        run_o;
  logic        irq_o;
  logic [31:0] rd;
  int          fail_count;
  int          n_compared;
  int          evt_seen;
  int          tk;

  icr_field fm (.clock_i(clock_i), .raw_o(raw_i));
  icr_top #(.TICK_CYC(4)) uut (
    .clock_i (clock_i), .reset_i (reset_i),
    .avs_address_i (avs_address_i), .avs_read_i (avs_read_i),
    .avs_write_i (avs_write_i), .avs_writedata_i (avs_writedata_i),
    .avs_readdata_o (avs_readdata_o),
    .avs_waitrequest_o (avs_waitrequest_o),
    .raw_i (raw_i), .scan_start_i (scan_start_i), .state_o (state_o),
    .lamp_o (lamp_o), .task_evt_o (task_evt_o),
    .counter_feed_o (counter_feed_o), .pulse_feed_o (pulse_feed_o),
    .run_o (run_o), .irq_o (irq_o));

  // ***************
  // Helpers
  // ***************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    avs_address_i <= a;
    avs_read_i <= !w;
    avs_write_i <= w;
    avs_writedata_i <= d;
    do begin
      @(posedge clock_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    if (n >= 50) chk(32'h1, 32'h0);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // Lamp 0..13, then run, then interrupt
  function automatic logic pick(input int i);
    if (i < 14) return lamp_o[i];
    return (i == 14) ? run_o : irq_o;
  endfunction

  task automatic wait_for(input int i, input logic v);
    int n;
    n = 0;
    while (pick(i) !== v && n < 60) begin
      @(posedge clock_i);
      n++;
    end
    chk(32'(pick(i)), 32'(v));
  endtask

  task automatic scan;
    @(posedge clock_i);
    scan_start_i <= 1'b1;
    @(posedge clock_i);
    scan_start_i <= 1'b0;
    @(posedge clock_i);
  endtask

  // Reference role after a write: illegal roles fall back to none
  function automatic int exp_role(input int ch, input int r);
    if (r < 5) return (ch < 8) ? r : 0;
    return (ch inside {8, 9, 11, 12}) ? r : 0;
  endfunction

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ***************
  // Clock, watchdog, event monitor
  // ***************
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  initial begin
    #(20000 * 10);
    fail_count++;
    wrap_up();
  end

  always @(posedge clock_i) begin
    if (task_evt_o[tk] === 1'b1) evt_seen++;
  end

  // ***************
  // Tests
  // ***************
  initial begin
    int ch, p, e;
    reset_i = 1'b1;
    avs_address_i = 6'h00;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    scan_start_i = 1'b0;
    tk = 0;
    p = $urandom(27);
    repeat (4) @(posedge clock_i);
    reset_i <= 1'b0;
    for (ch = 0; ch < 14; ch++) begin
      wr(6'h28, ch);
      rdchk(6'h20, 32'h0);
    end
    rdchk(6'h04, 32'h0);
    wr(6'h3C, 32'hFFFFFFFF);
    rdchk(6'h3C, 32'h0);
    $display("test defaults done");
    for (ch = 0; ch < 14; ch++) begin
      wr(6'h28, ch);
      for (p = 2; p < 6; p++) begin
        wr(6'h20, p);
        rdchk(6'h20, exp_role(ch, p));
      end
      wr(6'h20, 32'h0);
    end
    $display("test roles done");
    // Counter role on a fast input, then pulse role on 8, 9, 11 or 12
    for (e = 0; e < 2; e++) begin
      ch = (e == 0) ? $urandom % 8 : 8 + $urandom % 4;
      if (ch >= 10) ch++;
      wr(6'h28, ch);
      wr(6'h20, 32'h4 + e);
      fm.set(ch, 1'b1);
      wait_for(ch, 1'b1);
      chk(32'(counter_feed_o), (e == 0) ? 32'h1 << ch : 32'h0);
      chk(32'(pulse_feed_o), (e == 1) ? 32'h1 << ch : 32'h0);
      fm.set(ch, 1'b0);
      wait_for(ch, 1'b0);
      chk(32'(counter_feed_o | pulse_feed_o), 32'h0);
      wr(6'h20, 32'h0);
    end
    $display("test feeds done");
    wr(6'h28, 32'h5);
    wr(6'h24, 32'h3);
    fm.set(5, 1'b1);
    repeat (6) @(posedge clock_i);
    chk(32'(lamp_o[5]), 32'h0);
    wait_for(5, 1'b1);
    fm.set(5, 1'b0);
    wait_for(5, 1'b0);
    wr(6'h24, 32'h0);
    $display("test integrator done");
    ch = $urandom % 8;
    wr(6'h28, ch);
    wr(6'h20, 32'h2);
    fm.pulse(ch, 8 + $urandom % 8);
    wait_for(ch, 1'b0);
    chk(32'(state_o[ch]), 32'h0);
    rdchk(6'h18, 32'h1 << ch);
    scan();
    chk(32'(state_o[ch]), 32'h1);
    scan();
    chk(32'(state_o[ch]), 32'h0);
    fm.set(ch, 1'b1);
    wait_for(ch, 1'b1);
    scan();
    scan();
    fm.set(ch, 1'b0);
    wait_for(ch, 1'b0);
    rdchk(6'h18, 32'h0);
    scan();
    chk(32'(state_o[ch]), 32'h0);
    wr(6'h20, 32'h0);
    $display("test latch done");
    ch = $urandom % 8;
    tk = $urandom % 4;
    wr(6'h28, ch);
    wr(6'h10, 32'h1 << tk);
    for (e = 0; e < 3; e++) begin
      wr(6'h0C, 32'h7F);
      wr(6'h20, 32'h3 | (e << 4) | (tk << 6));
      evt_seen = 0;
      fm.set(ch, 1'b1);
      wait_for(ch, 1'b1);
      repeat (4) @(posedge clock_i);
      chk(evt_seen, 32'(e != 1));
      chk(32'(irq_o), 32'(e != 1));
      fm.set(ch, 1'b0);
      wait_for(ch, 1'b0);
      repeat (4) @(posedge clock_i);
      chk(evt_seen, int'(e != 1) + int'(e != 0));
      rdchk(6'h0C, 32'h1 << tk);
      wr(6'h0C, 32'h1 << tk);
      wait_for(15, 1'b0);
    end
    wr(6'h10, 32'h0);
    fm.set(ch, 1'b1);
    wait_for(ch, 1'b1);
    repeat (4) @(posedge clock_i);
    chk(32'(irq_o), 32'h0);
    rdchk(6'h0C, 32'h1 << tk);
    wr(6'h20, 32'h0);
    fm.set(ch, 1'b0);
    $display("test events done");
    ch = 8 + $urandom % 6;
    wr(6'h04, 32'h1 | (ch << 1));
    wr(6'h28, ch);
    wr(6'h20, 32'h5);
    rdchk(6'h20, 32'h1);
    wr(6'h08, 32'h1);
    repeat (4) @(posedge clock_i);
    chk(32'(run_o), 32'h0);
    rdchk(6'h08, 32'h0);
    fm.set(ch, 1'b1);
    wait_for(14, 1'b1);
    rdchk(6'h08, 32'h3);
    wr(6'h08, 32'h2);
    wait_for(14, 1'b0);
    wr(6'h08, 32'h1);
    wait_for(14, 1'b1);
    fm.set(ch, 1'b0);
    wait_for(14, 1'b0);
    $display("test run stop done");
    wrap_up();
  end
endmodule
